// *** socd_pkg.sv ***
// Constants and types for the scan output control decoder
package socd_pkg;
	localparam int unsigned CLK_HZ            = 40_000_000;
	localparam int unsigned PKT_INTERVAL_US   = 8_000;
	localparam int unsigned PKT_INTERVAL_CYC  = (PKT_INTERVAL_US * (CLK_HZ / 1_000_000));
	localparam int unsigned HOLD_W            = 24;
	localparam int unsigned WORD_W            = 16;
	localparam int unsigned NQUAL             = 4;
	// Control word bit positions
	localparam int unsigned BIT_XFER_EN       = 0;
	localparam int unsigned BIT_HANDSHAKE     = 1;
	localparam int unsigned BIT_FRAGMENT      = 2;
	localparam int unsigned BIT_CLR_FAULT     = 4;
	localparam int unsigned BIT_SCAN_START    = 5;
	localparam int unsigned BIT_SCAN_STOP     = 6;
	localparam int unsigned BIT_IND_TRIGGER   = 7;
	// Qualifier slots
	localparam logic [1:0]  Q_XFER            = 2'h0;
	localparam logic [1:0]  Q_CLR             = 2'h1;
	localparam logic [1:0]  Q_START           = 2'h2;
	localparam logic [1:0]  Q_STOP            = 2'h3;
	// Reset values
	localparam logic [15:0] WORD_RST          = 16'h0000;
	localparam logic [15:0] ACK_ERROR         = 16'h0000;

	typedef enum logic [0:0] {
		RS_RUN  = 1'b0,
		RS_WAIT = 1'b1
	} socd_rs_t;

	typedef struct packed {
		logic [15:0]                  ctrl;
		logic [15:0]                  ack;
		logic [NQUAL-1:0]             armed;
		logic [NQUAL-1:0][HOLD_W-1:0] hold;
		logic                         xfer_en;
		logic                         hs_mode;
		logic                         frag_mode;
		logic                         cache_ovf;
		logic                         fault_clr;
		logic                         scan_start;
		logic                         scan_stop;
		logic                         scan_active;
		logic                         ind_send;
		logic [15:0]                  ind_code;
		logic                         data_grant;
		logic                         restart;
		socd_rs_t                     rs;
	} socd_state_t;
endpackage : socd_pkg

// *** socd_decoder.sv ***
// Output image decoder: control qualification, mode latch, scan and indication commands, ack handshake
`timescale 1ns/10ps
`default_nettype none
module socd_decoder
	import socd_pkg::*;
#(
	parameter int unsigned PKT_CYC = PKT_INTERVAL_CYC
) (
	// Clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// Cyclic output image from the controller
	input  wire logic        image_valid,
	input  wire logic [15:0] transfer_control_word,
	input  wire logic [15:0] acknowledge_count_word,
	input  wire logic [15:0] indication_code_word,
	// Input-side status and scanner events
	input  wire logic [15:0] update_count,
	input  wire logic        cache_full_evt,
	input  wire logic        barcode_read,
	// Scanner commands
	output var  logic        scan_start,
	output var  logic        scan_stop,
	output var  logic        scan_active,
	output var  logic        ind_send,
	output var  logic [15:0] user_indication_code,
	// Transfer state
	output var  logic        xfer_enabled,
	output var  logic        hs_mode,
	output var  logic        frag_mode,
	output var  logic        data_grant,
	output var  logic        resync_req,
	output var  logic        restart,
	output var  logic        fault_clear,
	output var  logic        cache_overflow
);

	// Whole decoder state in one register
	socd_state_t s_q;
	socd_state_t s_d;

	// Control bit watched by each qualifier slot
	function automatic int unsigned qual_bit(input logic [1:0] slot);
		unique case (slot)
			Q_XFER:  qual_bit = BIT_XFER_EN;
			Q_CLR:   qual_bit = BIT_CLR_FAULT;
			Q_START: qual_bit = BIT_SCAN_START;
			Q_STOP:  qual_bit = BIT_SCAN_STOP;
		endcase
	endfunction : qual_bit

	// Bit went from 0 to 1 between two successive images
	function automatic logic rise(input logic [15:0] old_w, input logic [15:0] new_w, input int unsigned b);
		rise = new_w[b] & ~old_w[b];
	endfunction : rise

	// Controller zeroed its acknowledge counter in the image just taken
	function automatic logic ack_zeroed(input logic valid, input logic [15:0] old_ack, input logic [15:0] new_ack);
		ack_zeroed = valid & (new_ack == ACK_ERROR) & (old_ack != ACK_ERROR);
	endfunction : ack_zeroed

	// Per-cycle helpers
	logic [NQUAL-1:0] fire;
	logic [15:0]      ack_eff;
	logic             ack_drop;

	always_comb begin
		s_d = s_q;
		fire = '0;
		// One-cycle commands default low
		s_d.fault_clr  = 1'b0;
		s_d.scan_start = 1'b0;
		s_d.scan_stop  = 1'b0;
		s_d.ind_send   = 1'b0;
		s_d.restart    = 1'b0;

		// Qualification timers: run while armed, fire after a full interval held
		for (int i = 0; i < NQUAL; i++) begin
			if (s_q.armed[i]) begin
				// Full interval held: act once and disarm
				if (s_q.hold[i] >= HOLD_W'(PKT_CYC - 1)) begin
					fire[i] = 1'b1;
					s_d.armed[i] = 1'b0;
				end else begin
					s_d.hold[i] = s_q.hold[i] + HOLD_W'(1);
				end
			end
		end

		if (image_valid) begin
			// Only bits 0,1,2,4,5,6,7 are looked at
			s_d.ctrl = transfer_control_word;
			s_d.ack  = acknowledge_count_word;
			// A rise arms the timer, a low level cancels it
			for (int i = 0; i < NQUAL; i++) begin
				if (rise(s_q.ctrl, transfer_control_word, qual_bit(2'(i)))) begin
					s_d.armed[i] = 1'b1;
					s_d.hold[i]  = '0;
				end else if (!transfer_control_word[qual_bit(2'(i))]) begin
					s_d.armed[i] = 1'b0;
					fire[i] = 1'b0;
				end
			end
			// Indication acts on the bare edge, no hold needed
			if (rise(s_q.ctrl, transfer_control_word, BIT_IND_TRIGGER)) begin
				s_d.ind_send = 1'b1;
				s_d.ind_code = indication_code_word;
			end
			// Enable low stops transfer at once, no hold
			if (!transfer_control_word[BIT_XFER_EN]) begin
				s_d.xfer_en = 1'b0;
			end
		end

		// Mode bits taken from the image stored when the enable qualifies
		if (fire[Q_XFER]) begin
			s_d.xfer_en   = 1'b1;
			s_d.hs_mode   = s_q.ctrl[BIT_HANDSHAKE];
			s_d.frag_mode = s_q.ctrl[BIT_FRAGMENT];
			if (!s_q.ctrl[BIT_HANDSHAKE]) begin
				s_d.frag_mode = 1'b0;
			end
		end

		// Fault clear; a new overflow in the same cycle wins
		if (fire[Q_CLR]) begin
			s_d.fault_clr = 1'b1;
			s_d.cache_ovf = 1'b0;
		end
		if (cache_full_evt) begin
			s_d.cache_ovf = 1'b1;
		end

		// Stop wins over start when both qualify together
		if (fire[Q_START] && !fire[Q_STOP]) begin
			s_d.scan_start  = 1'b1;
			s_d.scan_active = 1'b1;
		end
		if (fire[Q_STOP] && s_q.scan_active) begin
			s_d.scan_stop   = 1'b1;
			s_d.scan_active = 1'b0;
		end
		// A read ends the scan unless a start fires with it
		if (barcode_read && s_q.scan_active && !fire[Q_START]) begin
			s_d.scan_active = 1'b0;
		end

		// Acknowledge counter seen only in handshake mode
		ack_eff  = s_q.hs_mode ? s_q.ack : update_count;
		ack_drop = ack_zeroed(image_valid, s_q.ack, acknowledge_count_word);

		// Entered once per zeroing, so a held zero cannot retrigger it
		unique case (s_q.rs)
			RS_RUN: begin
				if (s_q.hs_mode && s_q.xfer_en && ack_drop) begin
					s_d.rs = RS_WAIT;
				end
			end
			RS_WAIT: begin
				// Both counters zero restarts; leaving handshake just ends the wait
				if (!s_q.hs_mode || (update_count == WORD_RST && s_q.ack == ACK_ERROR)) begin
					s_d.rs      = RS_RUN;
					s_d.restart = s_q.hs_mode;
				end
			end
		endcase

		// Input data may be loaded only while enabled, in step and acknowledged
		s_d.data_grant = s_d.xfer_en & (s_d.rs == RS_RUN);
		if (ack_eff != update_count) begin
			s_d.data_grant = 1'b0;
		end
	end

	// Clock enable low freezes every field, timers included
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// Every output straight from a state register field
	assign scan_start           = s_q.scan_start;
	assign scan_stop            = s_q.scan_stop;
	assign scan_active          = s_q.scan_active;
	assign ind_send             = s_q.ind_send;
	assign user_indication_code = s_q.ind_code;
	assign xfer_enabled         = s_q.xfer_en;
	assign hs_mode              = s_q.hs_mode;
	assign frag_mode            = s_q.frag_mode;
	assign data_grant           = s_q.data_grant;
	assign resync_req           = (s_q.rs == RS_WAIT);
	assign restart              = s_q.restart;
	assign fault_clear          = s_q.fault_clr;
	assign cache_overflow       = s_q.cache_ovf;

endmodule : socd_decoder
`default_nettype wire

// *** socd_checker.sv ***
// Assertion checker for the scan output control decoder
`timescale 1ns/10ps
`default_nettype none
module socd_checker
	import socd_pkg::*;
#(parameter int unsigned PKT_CYC = PKT_INTERVAL_CYC) (
	// Clock, reset and image
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        ce,
	input wire logic        image_valid,
	input wire logic [15:0] transfer_control_word,
	input wire logic [15:0] indication_code_word,
	input wire logic        barcode_read,
	// Watched outputs
	input wire logic        scan_start,
	input wire logic        scan_stop,
	input wire logic        scan_active,
	input wire logic        ind_send,
	input wire logic [15:0] user_indication_code,
	input wire logic        hs_mode,
	input wire logic        frag_mode,
	input wire logic        xfer_enabled,
	input wire logic        fault_clear,
	input wire logic        cache_overflow
);
	localparam int LM = PKT_CYC - 1;
	logic [15:0]      prev_q;
	wire logic        tk   = ce && image_valid;
	wire logic [15:0] rise = {16{tk}} & transfer_control_word & ~prev_q;
	wire logic [15:0] drop = {16{tk}} & ~transfer_control_word;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) prev_q <= 16'h0000;
		else if (tk) prev_q <= transfer_control_word;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Rise, then a full interval with no image dropping the bit
	sequence s_held(r, d);
		r ##1 (!d throughout (1'b1 ##LM 1'b1));
	endsequence
	property p_fire(r, d, o);
		s_held(r, d) |-> ##[0:2] o;
	endproperty
	AST_START: assert property (p_fire(rise[5], drop[5], scan_start)) else $error("no scan start");
	AST_CLEAR: assert property (p_fire(rise[4], drop[4], fault_clear)) else $error("no fault clear");
	AST_IND: assert property (rise[7] |=> ind_send && user_indication_code == $past(indication_code_word))
		else $error("indication not sent");
	AST_STOP: assert property (scan_stop |-> $past(scan_active)) else $error("stop without scan");
	AST_READ: assert property (scan_active && barcode_read |=> !scan_active || scan_start) else $error("scan kept");
	AST_FRAG: assert property (frag_mode |-> hs_mode) else $error("frag without handshake");
	AST_MODE: assert property (xfer_enabled && $past(xfer_enabled) |-> $stable(hs_mode) && $stable(frag_mode))
		else $error("mode changed");
	AST_OVF: assert property ($fell(cache_overflow) |-> fault_clear || $past(fault_clear)) else $error("ovf lost");
endmodule : socd_checker
`default_nettype wire

// *** socd_plc.sv ***
// Controller model writing cyclic output images
`timescale 1ns/10ps
`default_nettype none
module socd_plc (
	// Clock and image
	input  wire logic        core_clk,
	output var  logic        image_valid,
	output var  logic [15:0] transfer_control_word,
	output var  logic [15:0] acknowledge_count_word,
	output var  logic [15:0] indication_code_word
);
	initial begin
		image_valid = 1'b0;
		{transfer_control_word, acknowledge_count_word, indication_code_word} = 48'h0;
	end
	// One image, then words inverted while invalid
	task automatic send(input logic [15:0] c, input logic [15:0] a, input logic [15:0] u);
		@(posedge core_clk);
		image_valid <= 1'b1;
		{transfer_control_word, acknowledge_count_word, indication_code_word} <= {c, a, u};
		@(posedge core_clk);
		image_valid <= 1'b0;
		{transfer_control_word, acknowledge_count_word, indication_code_word} <= ~{c, a, u};
	endtask : send
endmodule : socd_plc
`default_nettype wire

// *** tb.sv ***
// Testbench for the scan output control decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
	import socd_pkg::*;
	localparam int unsigned PKT = 8;
	int err_count = 0;
	int compares = 0;
	logic core_clk, rst_n, ce, cache_full_evt, barcode_read;
	logic [15:0] update_count, user_indication_code;
	logic scan_start, scan_stop, scan_active, ind_send, xfer_enabled, hs_mode, frag_mode;
	logic data_grant, resync_req, restart, fault_clear, cache_overflow;
	wire logic image_valid;
	wire logic [15:0] transfer_control_word, acknowledge_count_word, indication_code_word;
	wire logic [4:0] pulses = {restart, fault_clear, ind_send, scan_stop, scan_start};
	logic [7:0] cnt [5];
	socd_plc u_plc (.*);
	socd_decoder #(.PKT_CYC(PKT)) u_dut (.*);
	always @(posedge core_clk) foreach (cnt[i]) cnt[i] <= rst_n ? cnt[i] + {7'h00, pulses[i]} : 8'h00;
	task automatic img(input logic [15:0] c, input logic [15:0] a = 16'h0005, input logic [15:0] u = 16'h0000);
		u_plc.send(c, a, u);
	endtask : img
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : tick
	task automatic t_start;
		img(16'hFF29);
		tick(PKT + 4);
		`CHK("xfer", 1'b1, xfer_enabled)
		`CHK("active", 1'b1, scan_active)
		img(16'hFF69);
		img(16'hFF29);
		tick(PKT + 4);
		`CHK("stops", 8'h00, cnt[1])
		img(16'hFF69);
		tick(PKT + 4);
		`CHK("stops", 8'h01, cnt[1])
		`CHK("active", 1'b0, scan_active)
		img(16'h0001);
		img(16'h0021);
		tick(PKT + 4);
		`CHK("starts", 8'h02, cnt[0])
		@(posedge core_clk);
		barcode_read <= 1'b1;
		@(posedge core_clk);
		barcode_read <= 1'b0;
		tick(2);
		`CHK("active", 1'b0, scan_active)
		$display("start test done");
	endtask : t_start
	task automatic t_mode;
		img(16'h0000);
		tick(2);
		`CHK("grant", 2'b00, {xfer_enabled, data_grant})
		img(16'h0007);
		tick(PKT + 4);
		`CHK("modes", 2'b11, {hs_mode, frag_mode})
		img(16'h0005);
		tick(PKT + 4);
		`CHK("hs", 2'b11, {hs_mode, data_grant})
		img(16'h0005, 16'h0000);
		tick(2);
		`CHK("resync", 1'b1, resync_req)
		@(posedge core_clk);
		update_count <= 16'h0000;
		tick(3);
		`CHK("restart", 9'h002, {cnt[4], resync_req})
		@(posedge core_clk);
		update_count <= 16'h0005;
		tick(2);
		`CHK("grant", 1'b0, data_grant)
		img(16'h0000);
		img(16'h0005, 16'h0000);
		tick(PKT + 4);
		`CHK("modes", 2'b00, {hs_mode, frag_mode})
		`CHK("basic", 2'b01, {resync_req, data_grant})
		$display("mode test done");
	endtask : t_mode
	task automatic t_ind;
		img(16'h0085, 16'h0005, 16'h3C5A);
		tick(1);
		img(16'h0085, 16'h0005, 16'h1234);
		tick(1);
		`CHK("inds", 8'h01, cnt[2])
		`CHK("code", 16'h3C5A, user_indication_code)
		$display("indication test done");
	endtask : t_ind
	task automatic t_fault;
		@(posedge core_clk);
		cache_full_evt <= 1'b1;
		@(posedge core_clk);
		cache_full_evt <= 1'b0;
		tick(PKT + 4);
		`CHK("ovf", 1'b1, cache_overflow)
		img(16'h0095);
		tick(PKT + 4);
		`CHK("ovf", 9'h002, {cnt[3], cache_overflow})
		$display("fault test done");
	endtask : t_fault
	task automatic t_ce;
		@(posedge core_clk);
		ce <= 1'b0;
		cache_full_evt <= 1'b1;
		@(posedge core_clk);
		cache_full_evt <= 1'b0;
		@(posedge core_clk);
		ce <= 1'b1;
		tick(2);
		`CHK("ovf", 1'b0, cache_overflow)
		$display("enable test done");
	endtask : t_ce
	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		{rst_n, ce, cache_full_evt, barcode_read} = 4'h4;
		update_count = 16'h0005;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_start();
		t_mode();
		t_ind();
		t_fault();
		t_ce();
		conclude();
	end
	initial begin
		#100000;
		err_count++;
		conclude();
	end
endmodule : tb
bind socd_decoder socd_checker #(.PKT_CYC(PKT_CYC)) u_chk (.*);
`default_nettype wire
